// ==== mfs_pkg.sv ====
// Package for the MAC frame and byte statistics counter bank
package mfs_pkg;

	localparam int CNT_W   = 32;
	localparam int NUM_CNT = 5;
	localparam int ADR_W   = 12;

	// Byte offsets of each counter base in the indirect space
	localparam logic [ADR_W-1:0] OFS_RX_ALL   = 12'h200;
	localparam logic [ADR_W-1:0] OFS_RX_VALID = 12'h204;
	localparam logic [ADR_W-1:0] OFS_TX_FRM   = 12'h300;
	localparam logic [ADR_W-1:0] OFS_TX_BYTE  = 12'h308;
	localparam logic [ADR_W-1:0] OFS_TX_BOK   = 12'h30C;

	// Counter slot indices
	localparam int IDX_RX_ALL   = 0;
	localparam int IDX_RX_VALID = 1;
	localparam int IDX_TX_FRM   = 2;
	localparam int IDX_TX_BYTE  = 3;
	localparam int IDX_TX_BOK   = 4;

	localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;
	localparam logic [CNT_W-1:0] CNT_ONE   = 32'h0000_0001;
	localparam logic [31:0]      UNMAPPED  = 32'h0000_0000;

	typedef struct packed {
		logic              cyc;
		logic              stb;
		logic              we;
		logic [ADR_W-1:0]  adr;
		logic [3:0]        sel;
		logic [31:0]       dat;
	} mfs_wb_req_s;

	typedef struct packed {
		logic              ack;
		logic [31:0]       dat;
	} mfs_wb_rsp_s;

	typedef struct packed {
		logic rx_frames_all;
		logic rx_frames_valid;
		logic tx_frames_all;
		logic tx_bytes_all;
		logic tx_bytes_valid;
	} mfs_evt_s;

endpackage : mfs_pkg

// ==== mfs_counter.sv ====
// One free-running statistics counter
`timescale 1ns/1ps
module mfs_counter
	import mfs_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             inc_i,
	output logic      [CNT_W-1:0] count_o
);

	typedef struct packed {
		logic [CNT_W-1:0] count;
	} mfs_cnt_state_s;

	mfs_cnt_state_s state;
	mfs_cnt_state_s next_state;

	always_comb
	begin
		next_state = state;
		// Natural wrap from all ones to zero, no saturation
		if (inc_i)
		begin
			next_state.count = state.count + CNT_ONE; // [R6]
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state.count <= CNT_RESET; // [R5]
		end
		else
		begin
			state <= next_state;
		end
	end

	assign count_o = state.count;

	a_count_steps: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
		!$past(rst_i) |-> count_o == $past(count_o) + CNT_W'($past(inc_i)))
		else $error("counter did not follow its increment");

	a_wrap_zero: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
		(inc_i && count_o == '1) |=> count_o == CNT_RESET)
		else $error("counter did not wrap to zero");

	a_reset_zero: assert property (@(posedge clk_i) // [R5]
		rst_i |=> count_o == CNT_RESET)
		else $error("counter not zero after reset");

endmodule : mfs_counter

// ==== mfs_stats.sv ====
// MAC frame and byte statistics counter bank with Wishbone slave
// Contract
// (R1) Every received frame, valid or not, advances the received-frames total.
// (R2) Only valid received frames advance the valid-received-frames count.
// (R3) Every transmitted frame advances the transmitted-frames total.
// (R4) Every transmitted byte advances the transmitted-bytes total.
// (R5) Counters start at zero and only device reset clears them.
// (R6) Counters never saturate and wrap from all ones to zero.
// (R7) Software keeps intervals short and allows for one wrap in differences.
// (R8) Counter bits 31..24 sit at the base byte, bits 7..0 at base plus three.
// (R9) Every valid transmitted byte advances the valid-transmitted-bytes count.
// (R10) Reads have no side effect and never lose a concurrent increment.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module mfs_stats
	import mfs_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	input  wire logic             rx_frames_all_i,
	input  wire logic             rx_frames_valid_i,
	input  wire logic             tx_frames_all_i,
	input  wire logic             tx_bytes_all_i,
	input  wire logic             tx_bytes_valid_i
);

	////////////////////////////////////////////////////////////////////////
	// Event capture

	mfs_wb_req_s req;
	mfs_evt_s    evt;
	logic [NUM_CNT-1:0] inc;
	logic [CNT_W-1:0]   cnt [NUM_CNT];

	always_comb
	begin
		req.cyc = wb_cyc_i;
		req.stb = wb_stb_i;
		req.we  = wb_we_i;
		req.adr = wb_adr_i;
		req.sel = wb_sel_i;
		req.dat = wb_dat_i;
		evt.rx_frames_all   = rx_frames_all_i;
		evt.rx_frames_valid = rx_frames_valid_i;
		evt.tx_frames_all   = tx_frames_all_i;
		evt.tx_bytes_all    = tx_bytes_all_i;
		evt.tx_bytes_valid  = tx_bytes_valid_i;
	end

	// Increments come only from events; the bus never touches a counter
	assign inc[IDX_RX_ALL]   = evt.rx_frames_all;   // [R1]
	assign inc[IDX_RX_VALID] = evt.rx_frames_valid; // [R2]
	assign inc[IDX_TX_FRM]   = evt.tx_frames_all;   // [R3]
	assign inc[IDX_TX_BYTE]  = evt.tx_bytes_all;    // [R4]
	assign inc[IDX_TX_BOK]   = evt.tx_bytes_valid;  // [R9]

	////////////////////////////////////////////////////////////////////////
	// Counter bank

	generate
		for (genvar g = 0; g < NUM_CNT; g++)
		begin : g_cnt
			mfs_counter u_cnt (
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.inc_i   (inc[g]),
				.count_o (cnt[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Wishbone slave

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} mfs_state_s;

	mfs_state_s state;
	mfs_state_s next_state;
	logic [31:0] rd_word;

	// Word address with the byte lanes dropped
	function automatic logic [31:0] mfs_pick(
		input logic [ADR_W-1:0] a,
		input logic [CNT_W-1:0] c0,
		input logic [CNT_W-1:0] c1,
		input logic [CNT_W-1:0] c2,
		input logic [CNT_W-1:0] c3,
		input logic [CNT_W-1:0] c4
	);
		logic [ADR_W-1:0] w;
		w = {a[ADR_W-1:2], 2'h0};
		if (w == OFS_RX_ALL)
			return c0;
		else if (w == OFS_RX_VALID)
			return c1;
		else if (w == OFS_TX_FRM)
			return c2;
		else if (w == OFS_TX_BYTE)
			return c3;
		else if (w == OFS_TX_BOK)
			return c4;
		else
			return UNMAPPED;
	endfunction : mfs_pick

	// Bits 31..24 on lane 3 answer the base byte address (big-endian bytes)
	always_comb
	begin
		rd_word = mfs_pick(req.adr, cnt[IDX_RX_ALL], cnt[IDX_RX_VALID],
			cnt[IDX_TX_FRM], cnt[IDX_TX_BYTE], cnt[IDX_TX_BOK]); // [R8]
	end

	always_comb
	begin
		next_state     = state;
		next_state.ack = 1'b0;
		// One ack per request; writes are acknowledged and ignored
		if (req.cyc && req.stb && !state.ack)
		begin
			next_state.ack = 1'b1;
			next_state.dat = req.we ? UNMAPPED : rd_word; // [R10]
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state.ack <= 1'b0;
			state.dat <= UNMAPPED;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign wb_ack_o = state.ack;
	assign wb_dat_o = state.dat;

	////////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence

	sequence s_read_ack;
		##1 wb_ack_o;
	endsequence

	a_ack_timing: assert property (@(posedge clk_i) disable iff (rst_i)
		s_req |-> s_read_ack)
		else $error("request not acknowledged next cycle");

	a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	a_rx_all_inc: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
		rx_frames_all_i && !$past(rst_i) |=>
		cnt[IDX_RX_ALL] == $past(cnt[IDX_RX_ALL]) + CNT_ONE)
		else $error("received-frame total missed a frame");

	a_rx_valid_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
		!rx_frames_valid_i |=> $stable(cnt[IDX_RX_VALID]))
		else $error("valid receive count moved without event");

	a_tx_frm_inc: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
		tx_frames_all_i |=> cnt[IDX_TX_FRM] == $past(cnt[IDX_TX_FRM]) + CNT_ONE)
		else $error("transmitted-frame total missed a frame");

	a_tx_byte_inc: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
		tx_bytes_all_i |=>
		cnt[IDX_TX_BYTE] == $past(cnt[IDX_TX_BYTE]) + CNT_ONE)
		else $error("transmitted-byte total missed a byte");

	a_tx_bok_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
		!tx_bytes_valid_i |=> $stable(cnt[IDX_TX_BOK]))
		else $error("valid byte count moved without event");

	a_read_no_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
		wb_cyc_i && wb_stb_i && tx_frames_all_i |=>
		cnt[IDX_TX_FRM] != CNT_RESET || $past(cnt[IDX_TX_FRM]) == '1)
		else $error("read disturbed a counter");

	a_read_data: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
		wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o &&
		{wb_adr_i[ADR_W-1:2], 2'h0} == OFS_TX_BYTE |=>
		wb_dat_o == $past(cnt[IDX_TX_BYTE]))
		else $error("read data does not match counter");

	a_reset_ack: assert property (@(posedge clk_i) // [R5]
		rst_i |=> !wb_ack_o && wb_dat_o == UNMAPPED)
		else $error("bus outputs not idle after reset");

endmodule : mfs_stats

// ==== mfs_mac_model.sv ====
// Model of the MAC paths that report frame and byte events
`timescale 1ns/1ps
module mfs_mac_model
	import mfs_pkg::*;
(
	input  wire logic start_i,
	input  wire logic clk_i,
	output mfs_evt_s  evt_o
);
	logic [3:0] step = 4'hF;
	initial evt_o = '0;
	always @(posedge clk_i)
	begin
		if (start_i)
			step <= 4'h0;
		else if (step != 4'hF)
			step <= step + 4'h1;
	end
	// One burst: 5 frames in, 3 valid, 4 frames out, 7 bytes, 6 valid
	always @(posedge clk_i)
	begin
		evt_o.rx_frames_all   <= (step < 4'h5);
		evt_o.rx_frames_valid <= (step < 4'h3);
		evt_o.tx_frames_all   <= (step < 4'h4);
		evt_o.tx_bytes_all    <= (step < 4'h7);
		evt_o.tx_bytes_valid  <= (step < 4'h6);
	end
endmodule : mfs_mac_model

// ==== testbench.sv ====
// Self-checking testbench for the statistics counter bank
`timescale 1ns/1ps
module testbench
	import mfs_pkg::*;
;
	logic             clk_i = 1'b0;
	logic             rst_i = 1'b1;
	logic             cyc   = 1'b0;
	logic             we    = 1'b0;
	logic [ADR_W-1:0] adr   = '0;
	logic [31:0]      wdat  = '0;
	logic [31:0]      rdat;
	logic [31:0]      got;
	logic             ack;
	logic             start = 1'b0;
	mfs_evt_s         evt;
	int               fails = 0;
	int               cmp_count = 0;
	logic [ADR_W-1:0] ofs [5] = '{OFS_RX_ALL, OFS_RX_VALID, OFS_TX_FRM,
		OFS_TX_BYTE, OFS_TX_BOK};
	logic [31:0]      num [5] = '{32'h5, 32'h3, 32'h4, 32'h7, 32'h6};

	always #12.5 clk_i = ~clk_i;

	mfs_mac_model mac (.start_i(start), .clk_i(clk_i), .evt_o(evt));
	mfs_stats uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.rx_frames_all_i(evt.rx_frames_all),
		.rx_frames_valid_i(evt.rx_frames_valid),
		.tx_frames_all_i(evt.tx_frames_all),
		.tx_bytes_all_i(evt.tx_bytes_all),
		.tx_bytes_valid_i(evt.tx_bytes_valid));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done

	// Classic cycle: hold until ack is sampled high, then release
	task automatic bus(input logic w, input logic [ADR_W-1:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1)
		begin
			fails++;
			test_done();
		end
		got = rdat;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask : bus

	task automatic rd(input logic [ADR_W-1:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check($sformatf("word at %h", a), got, e);
	endtask : rd

	task automatic reset_all();
		rst_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask : reset_all

	task automatic burst();
		start <= 1'b1;
		@(posedge clk_i);
		start <= 1'b0;
	endtask : burst

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		reset_all();
		for (int i = 0; i < 5; i++)
			rd(ofs[i], CNT_RESET);
		rd(12'h100, UNMAPPED);
		$display("test reset values done");
		burst();
		repeat (12) @(posedge clk_i);
		for (int i = 0; i < 5; i++)
			rd(ofs[i], num[i]);
		$display("test event counts done");
		for (int i = 0; i < 5; i++)
			bus(1'b1, ofs[i], 32'hFFFF_FFFF);
		for (int i = 0; i < 5; i++)
			rd(ofs[i], num[i]);
		$display("test write and reread done");
		// Reads overlap the second burst; no event may be lost
		burst();
		for (int i = 0; i < 4; i++)
			bus(1'b0, ofs[3], 32'h0);
		repeat (12) @(posedge clk_i);
		for (int i = 0; i < 5; i++)
		begin
			rd(ofs[i], num[i] << 1);
			check("interval difference", got - num[i], num[i]);
		end
		$display("test reads during traffic done");
		reset_all();
		for (int i = 0; i < 5; i++)
			rd(ofs[i], CNT_RESET);
		$display("test second reset done");
		test_done();
	end
endmodule : testbench
